// >>> aics_top.sv
// Purpose: converter input select, conversion clock select and trigger routing
// Assumes: pins and other-domain inputs are synchronised here
// Notes:   conversion clock is a tick enable on sys_clk
//          wait mode gates nothing; deep stop halts alternate ticks
//
// Summary of operation
// - codes 0 to 15 connect the sixteen external pins in order
// - codes 16 to 18 select ground, 29 high reference, 30 low reference
// - reserved codes still convert, result undefined
// - all-ones code disables the converter, no input connected
// - code 22 temperature sensor, code 23 bandgap reference
// - clock source: bus, bus halved, local async, alternate
// - alternate clock comes from the external oscillator output
// - selected source passes the programmable divider to give conversion clock
// - alternate clock keeps running in wait mode
// - in deepest stop mode alternate clock gives no conversion ticks
// - four trigger sources, timer-two triggers each delayed by 8-bit count
// - all four triggers start conversions in run and wait modes
// - in deepest stop mode only real-time counter overflow triggers
// - successive approximation converter with 12-bit result
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module aics_top
   import aics_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  wait_mode,
   input  wire logic                  deep_stop_mode,
   input  wire logic                  local_async_conversion_clock,
   input  wire logic                  external_oscillator_output,
   input  wire logic                  modulo_timer_zero_ovf,
   input  wire logic                  rtc_ovf,
   input  wire logic                  timer_two_match,
   input  wire logic                  timer_two_init,
   input  wire logic                  cmp_hi,
   output logic [15:0]                ext_pin_sel,
   output logic [2:0]                 input_src,
   output logic                       module_enable,
   output logic [AICS_RES_W-1:0]      dac_code,
   output logic                       conversion_clock,
   output logic                       conv_busy
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [4:0]  chan;
      logic [1:0]  cksel;
      logic [1:0]  div;
      logic [1:0]  tsel;
      logic        ten;
      logic [7:0]  dly;
      logic        swstart;
      logic [2:0]  sy_lac;
      logic [2:0]  sy_osc;
      logic [2:0]  sy_mt;
      logic [2:0]  sy_rtc;
      logic [2:0]  sy_tm;
      logic [2:0]  sy_ti;
      logic        half;
      logic [2:0]  dcnt;
      logic        ck;
      logic        tick;
      logic        dly_run;
      logic [7:0]  dly_cnt;
      logic        dly_fire;
      logic [AICS_RES_W-1:0] res;
      logic        res_ok;
      logic [15:0] pins;
      logic [2:0]  src;
   } aics_top_s;
   aics_top_s s_q, s_d;

   // ------------------------------------------------------------
   // converter sequencer nets
   // ------------------------------------------------------------
   logic [AICS_RES_W-1:0] sar_res;
   logic                  sar_busy;
   logic                  sar_done;
   logic                  start;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [2:0] decode_src(input logic [4:0] c);
      if (c <= AICS_CH_EXT_MAX) decode_src = AICS_SRC_EXT;
      else if (c >= AICS_CH_GND_LO && c <= AICS_CH_GND_HI) decode_src = AICS_SRC_GND;
      else if (c == AICS_CH_HIGH_REFERENCE) decode_src = AICS_SRC_HIGH_REFERENCE;
      else if (c == AICS_CH_LOW_REFERENCE) decode_src = AICS_SRC_LOW_REFERENCE;
      else if (c == AICS_CH_TEMP) decode_src = AICS_SRC_TEMP;
      else if (c == AICS_CH_BGAP) decode_src = AICS_SRC_BGAP;
      else if (c == AICS_CH_OFF) decode_src = AICS_SRC_NONE;
      else decode_src = AICS_SRC_RSVD;
   endfunction : decode_src

   function automatic logic rise(input logic [2:0] sy);
      rise = sy[1] & ~sy[2];
   endfunction : rise

   function automatic logic [3:0] div_limit(input logic [1:0] d);
      div_limit = (4'h1 << d) - 4'h1;
   endfunction : div_limit

   function automatic logic delayed_src(input logic [1:0] t);
      delayed_src = (t == AICS_TR_T2MATCH) || (t == AICS_TR_T2INIT);
   endfunction : delayed_src

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == AICS_OFF_CHAN) || (a == AICS_OFF_CLK) || (a == AICS_OFF_TRIG) ||
                  (a == AICS_OFF_STAT) || (a == AICS_OFF_RESULT);
   endfunction : is_mapped

   // ------------------------------------------------------------
   // combinational helpers
   // ------------------------------------------------------------
   logic [3:0] div_max;
   logic       src_edge;
   logic       trig_raw;
   logic       alt_ok;

   always_comb begin
      s_d = s_q;
      s_d.swstart = 1'b0;
      s_d.tick = 1'b0;
      s_d.dly_fire = 1'b0;
      src_edge = 1'b0;
      trig_raw = 1'b0;
      alt_ok = 1'b1;
      div_max = 4'h0;

      // ------------------------------------------------------------
      // synchronisers: only bits 1 and 2 are read
      // ------------------------------------------------------------
      s_d.sy_lac = {s_q.sy_lac[1:0], local_async_conversion_clock};
      s_d.sy_osc = {s_q.sy_osc[1:0], external_oscillator_output};
      s_d.sy_mt  = {s_q.sy_mt[1:0], modulo_timer_zero_ovf};
      s_d.sy_rtc = {s_q.sy_rtc[1:0], rtc_ovf};
      s_d.sy_tm  = {s_q.sy_tm[1:0], timer_two_match};
      s_d.sy_ti  = {s_q.sy_ti[1:0], timer_two_init};

      // ------------------------------------------------------------
      // apb writes
      // ------------------------------------------------------------
      if (psel && penable && pwrite) begin
         case (paddr)
            AICS_OFF_CHAN: begin
               s_d.chan = pwdata[4:0];
               s_d.swstart = (pwdata[4:0] != AICS_CH_OFF);
            end
            AICS_OFF_CLK: begin
               s_d.cksel = pwdata[AICS_CLKSRC_LSB +: 2];
               s_d.div = pwdata[AICS_DIV_LSB +: 2];
            end
            AICS_OFF_TRIG: begin
               s_d.tsel = pwdata[AICS_TSEL_LSB +: 2];
               s_d.ten = pwdata[AICS_TEN_BIT];
               s_d.dly = pwdata[AICS_DLY_LSB +: 8];
            end
            default: ;
         endcase
      end

      // ------------------------------------------------------------
      // conversion clock source and divider
      // ------------------------------------------------------------
      s_d.half = ~s_q.half;

      case (s_q.cksel)
         AICS_CK_BUS:   src_edge = 1'b1;
         AICS_CK_BUS2:  src_edge = s_q.half;
         AICS_CK_LOCAL: src_edge = rise(s_q.sy_lac);
         AICS_CK_ALT: begin
            alt_ok = ~deep_stop_mode;
            src_edge = rise(s_q.sy_osc) & alt_ok;
         end
         default: src_edge = 1'b0;
      endcase

      div_max = div_limit(s_q.div);
      if (src_edge) begin
         if ({1'b0, s_q.dcnt} >= div_max) begin
            s_d.dcnt = 3'h0;
            s_d.tick = 1'b1;
            s_d.ck = ~s_q.ck;
         end else begin
            s_d.dcnt = s_q.dcnt + 3'h1;
         end
      end

      // ------------------------------------------------------------
      // hardware trigger routing
      // ------------------------------------------------------------
      if (s_q.ten) begin
         case (s_q.tsel)
            AICS_TR_MODTMR:  trig_raw = rise(s_q.sy_mt) & ~deep_stop_mode;
            AICS_TR_RTC:     trig_raw = rise(s_q.sy_rtc);
            AICS_TR_T2MATCH: trig_raw = rise(s_q.sy_tm) & ~deep_stop_mode;
            AICS_TR_T2INIT:  trig_raw = rise(s_q.sy_ti) & ~deep_stop_mode;
            default:         trig_raw = 1'b0;
         endcase
      end

      if (trig_raw && delayed_src(s_q.tsel)) begin
         s_d.dly_run = 1'b1;
         s_d.dly_cnt = s_q.dly;
      end else if (s_q.dly_run) begin
         if (s_q.dly_cnt == 8'h00) begin
            s_d.dly_run = 1'b0;
            s_d.dly_fire = 1'b1;
         end else begin
            s_d.dly_cnt = s_q.dly_cnt - 8'h01;
         end
      end

      // ------------------------------------------------------------
      // input mux and results
      // ------------------------------------------------------------
      s_d.src = decode_src(s_q.chan);
      s_d.pins = (s_q.chan <= AICS_CH_EXT_MAX) ? (16'h0001 << s_q.chan[3:0]) : 16'h0000;

      if (sar_done) begin
         s_d.res = sar_res;
         s_d.res_ok = 1'b1;
      end else if (start) begin
         s_d.res_ok = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // conversion start
   // ------------------------------------------------------------
   assign start = (s_q.swstart | s_q.dly_fire | (trig_raw & ~delayed_src(s_q.tsel)))
                  & (s_q.chan != AICS_CH_OFF) & ~sar_busy;

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.chan <= AICS_CHAN_RST;
         s_q.src <= AICS_SRC_NONE;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // converter sequencer
   // ------------------------------------------------------------
   aics_sar aics_sar_i (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .ce       (ce),
      .tick     (s_q.tick),
      .start    (start),
      .cmp_hi   (cmp_hi),
      .dac_code (dac_code),
      .result   (sar_res),
      .busy     (sar_busy),
      .done     (sar_done)
   );

   // ------------------------------------------------------------
   // apb read side
   // ------------------------------------------------------------
   always_comb begin
      case (paddr)
         AICS_OFF_CHAN:   prdata = {27'h0, s_q.chan};
         AICS_OFF_CLK:    prdata = {28'h0, s_q.div, s_q.cksel};
         AICS_OFF_TRIG:   prdata = {16'h0, s_q.dly, 5'h0, s_q.ten, s_q.tsel};
         AICS_OFF_STAT:   prdata = {29'h0, s_q.dly_run, s_q.res_ok, sar_busy};
         AICS_OFF_RESULT: prdata = {20'h0, s_q.res};
         default:         prdata = 32'h0;
      endcase
   end

   // ------------------------------------------------------------
   // apb response
   // ------------------------------------------------------------
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~is_mapped(paddr);

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign ext_pin_sel      = s_q.pins;
   assign input_src        = s_q.src;
   assign module_enable    = (s_q.chan != AICS_CH_OFF);
   assign conversion_clock = s_q.ck;
   assign conv_busy        = sar_busy;
endmodule : aics_top

// >>> aics_pkg.sv
// Purpose: constants for the converter input, clock and trigger select block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   all offsets are byte addresses
package aics_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] AICS_OFF_CHAN   = 8'h00;
   localparam logic [7:0] AICS_OFF_CLK    = 8'h04;
   localparam logic [7:0] AICS_OFF_TRIG   = 8'h08;
   localparam logic [7:0] AICS_OFF_STAT   = 8'h0C;
   localparam logic [7:0] AICS_OFF_RESULT = 8'h10;
   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int         AICS_CLKSRC_LSB = 0;
   localparam int         AICS_DIV_LSB    = 2;
   localparam int         AICS_TSEL_LSB   = 0;
   localparam int         AICS_TEN_BIT    = 2;
   localparam int         AICS_DLY_LSB    = 8;
   localparam logic [4:0] AICS_CHAN_RST   = 5'h1F;
   localparam logic [4:0] AICS_CH_EXT_MAX = 5'h0F;
   localparam logic [4:0] AICS_CH_GND_LO  = 5'h10;
   localparam logic [4:0] AICS_CH_GND_HI  = 5'h12;
   localparam logic [4:0] AICS_CH_TEMP    = 5'h16;
   localparam logic [4:0] AICS_CH_BGAP    = 5'h17;
   localparam logic [4:0] AICS_CH_HIGH_REFERENCE   = 5'h1D;
   localparam logic [4:0] AICS_CH_LOW_REFERENCE   = 5'h1E;
   localparam logic [4:0] AICS_CH_OFF     = 5'h1F;
   localparam int         AICS_RES_W      = 12;
   // ------------------------------------------------------------
   // enumerations
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      AICS_SRC_EXT, AICS_SRC_GND, AICS_SRC_TEMP, AICS_SRC_BGAP,
      AICS_SRC_HIGH_REFERENCE, AICS_SRC_LOW_REFERENCE, AICS_SRC_RSVD, AICS_SRC_NONE
   } aics_src_e;
   typedef enum logic [1:0] {
      AICS_CK_BUS, AICS_CK_BUS2, AICS_CK_LOCAL, AICS_CK_ALT
   } aics_cksel_e;
   typedef enum logic [1:0] {
      AICS_TR_MODTMR, AICS_TR_RTC, AICS_TR_T2MATCH, AICS_TR_T2INIT
   } aics_tsel_e;
endpackage : aics_pkg

// >>> aics_sar.sv
// Purpose: 12-bit successive approximation sequencer
// Assumes: comparator answer comes from the analog front end
// Notes:   steps once per conversion clock tick
`timescale 1ns/1ps
module aics_sar
   import aics_pkg::*;
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic                  tick,
   input  wire logic                  start,
   input  wire logic                  cmp_hi,
   output logic [AICS_RES_W-1:0]      dac_code,
   output logic [AICS_RES_W-1:0]      result,
   output logic                       busy,
   output logic                       done
);
   typedef enum logic [1:0] {AICS_S_IDLE, AICS_S_RUN, AICS_S_END} aics_sst_e;
   typedef struct packed {
      aics_sst_e             st;
      logic [3:0]            bitn;
      logic [AICS_RES_W-1:0] trial;
      logic [AICS_RES_W-1:0] res;
      logic                  done;
   } aics_sar_s;
   aics_sar_s s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      case (s_q.st)
         AICS_S_IDLE: begin
            if (start) begin
               s_d.st = AICS_S_RUN;
               s_d.bitn = 4'hB;
               s_d.trial = 12'h800;
            end
         end
         AICS_S_RUN: begin
            if (tick) begin
               // successive approximation bit decision
               if (!cmp_hi) s_d.trial[s_q.bitn] = 1'b0;
               if (s_q.bitn == 4'h0) begin
                  s_d.st = AICS_S_END;
               end else begin
                  s_d.bitn = s_q.bitn - 4'h1;
                  s_d.trial[s_q.bitn - 4'h1] = 1'b1;
               end
            end
         end
         AICS_S_END: begin
            s_d.res = s_q.trial;
            s_d.done = 1'b1;
            s_d.st = AICS_S_IDLE;
         end
         default: s_d.st = AICS_S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) s_q <= '{AICS_S_IDLE, 4'h0, 12'h000, 12'h000, 1'b0};
      else if (ce) s_q <= s_d;
   end

   assign dac_code = s_q.trial;
   assign result   = s_q.res;
   assign busy     = (s_q.st != AICS_S_IDLE);
   assign done     = s_q.done & ce;
endmodule : aics_sar

// >>> aics_chk.sv
// Purpose: port assertions for aics_top
// Assumes: one clock, sync reset
// Notes:   shadow regs track channel and clock writes
`timescale 1ns/1ps
module aics_chk
   import aics_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   input wire logic        deep_stop_mode,
   input wire logic [15:0] ext_pin_sel,
   input wire logic [2:0]  input_src,
   input wire logic        conversion_clock,
   input wire logic        conv_busy
);
   // ---
   // shadow state
   // ---
   logic [3:0] code_q;
   logic [1:0] src_q;
   logic [3:0] ds_q;
   logic       wr;
   assign wr = psel && penable && pwrite;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         code_q <= 4'h0;
         src_q  <= 2'h0;
         ds_q   <= 4'h0;
      end else begin
         if (wr && paddr == AICS_OFF_CHAN) begin
            code_q <= pwdata[3:0];
         end
         if (wr && paddr == AICS_OFF_CLK) begin
            src_q <= pwdata[1:0];
         end
         if (!deep_stop_mode || src_q != 2'h3) begin
            ds_q <= 4'h0;
         end else if (ds_q != 4'hF) begin
            ds_q <= ds_q + 4'h1;
         end
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_unmapped_err: assert property (psel && penable && paddr > AICS_OFF_RESULT |-> pslverr)
      else $error("no error on unmapped access");
   a_ext_pin_order: assert property (wr && paddr == AICS_OFF_CHAN && pwdata[4] == 1'b0
      |=> ##[0:1] ext_pin_sel == (16'h0001 << code_q)) else $error("wrong pin selected");
   a_pin_means_ext: assert property (|ext_pin_sel |-> input_src == AICS_SRC_EXT)
      else $error("pin selected for internal source");
   a_gnd_codes: assert property (wr && paddr == AICS_OFF_CHAN && pwdata[4:0] inside {[5'h10:5'h12]}
      |=> ##[0:1] input_src == AICS_SRC_GND && ext_pin_sel == 16'h0) else $error("ground not selected");
   a_sensor_codes: assert property (wr && paddr == AICS_OFF_CHAN && pwdata[4:1] == 4'hB
      |=> ##[0:1] input_src == (code_q[0] ? AICS_SRC_BGAP : AICS_SRC_TEMP)) else $error("sensor not selected");
   a_off_code: assert property (wr && paddr == AICS_OFF_CHAN && pwdata[4:0] == 5'h1F
      |=> ##[0:1] input_src == AICS_SRC_NONE && ext_pin_sel == 16'h0) else $error("input left connected");
   a_alt_stop: assert property (ds_q == 4'hF && src_q == 2'h3 && deep_stop_mode
      |=> $stable(conversion_clock)) else $error("alternate clock runs in deep stop");
   a_busy_min: assert property ($rose(conv_busy) |=> conv_busy[*8])
      else $error("conversion too short");
   a_reset_off: assert property ($fell(rst) |-> input_src == AICS_SRC_NONE && ext_pin_sel == 16'h0)
      else $error("channel not disabled after reset");
endmodule : aics_chk

bind aics_top aics_chk aics_chk_i (
   .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pslverr(pslverr), .deep_stop_mode(deep_stop_mode), .ext_pin_sel(ext_pin_sel),
   .input_src(input_src), .conversion_clock(conversion_clock), .conv_busy(conv_busy)
);

// >>> aics_afe_model.sv
// Purpose: analog source stand-in for aics_top
// Assumes: comparator sees selected level against trial code
// Notes:   reserved and disabled inputs answer with a changing pattern
`timescale 1ns/1ps
module aics_afe_model
   import aics_pkg::*;
#(
   parameter logic [11:0] TEMP_LVL = 12'h2C0,
   parameter logic [11:0] BGAP_LVL = 12'h4D8
)
(
   input  wire logic [15:0]           ext_pin_sel,
   input  wire logic [2:0]            input_src,
   input  wire logic [AICS_RES_W-1:0] dac_code,
   output logic                       cmp_hi
);
   // ---
   // level select
   // ---
   logic [11:0] lvl;
   always_comb begin
      lvl = 12'h000;
      for (int i = 0; i < 16; i++) begin
         if (ext_pin_sel[i]) begin
            lvl = 12'h0A5 + 12'(i) * 12'h0F1;
         end
      end
      case (input_src)
         AICS_SRC_TEMP:  lvl = TEMP_LVL;
         AICS_SRC_BGAP:  lvl = BGAP_LVL;
         AICS_SRC_HIGH_REFERENCE: lvl = 12'hFFF;
         AICS_SRC_GND:   lvl = 12'h000;
         default: ;
      endcase
      cmp_hi = (input_src >= AICS_SRC_RSVD) ? ^dac_code : (lvl >= dac_code);
   end
endmodule : aics_afe_model

// >>> aics_top_tb.sv
// Purpose: self-checking bench for aics_top
// Assumes: zero-wait apb slave, bus clock source after reset
// Notes:   reserved channel results are never compared
`timescale 1ns/1ps
module aics_top_tb
   import aics_pkg::*;
;
   localparam logic [11:0] TEMP_LVL = 12'h2C0;
   localparam logic [11:0] BGAP_LVL = 12'h4D8;
   logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, cmp_hi, e;
   logic        wait_mode, deep_stop_mode, module_enable, conversion_clock, conv_busy;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] ext_pin_sel;
   logic [11:0] dac_code;
   logic [2:0]  input_src, ckdiv;
   logic [3:0]  trg;
   logic [4:0]  c;
   int          bad_count, checked, k, n0;
   aics_top aics_top_i (
      .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wait_mode(wait_mode), .deep_stop_mode(deep_stop_mode), .local_async_conversion_clock(ckdiv[2]),
      .external_oscillator_output(ckdiv[1]), .modulo_timer_zero_ovf(trg[0]), .rtc_ovf(trg[1]),
      .timer_two_match(trg[2]), .timer_two_init(trg[3]), .cmp_hi(cmp_hi), .ext_pin_sel(ext_pin_sel),
      .input_src(input_src), .module_enable(module_enable), .dac_code(dac_code),
      .conversion_clock(conversion_clock), .conv_busy(conv_busy));
   aics_afe_model #(.TEMP_LVL(TEMP_LVL), .BGAP_LVL(BGAP_LVL)) aics_afe_model_i (
      .ext_pin_sel(ext_pin_sel), .input_src(input_src), .dac_code(dac_code), .cmp_hi(cmp_hi));
   // ---
   // helpers
   // ---
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) ckdiv <= ckdiv + 3'h1;
   function automatic logic [2:0] src_of(input logic [4:0] x);
      case (x)
         5'h10, 5'h11, 5'h12: src_of = AICS_SRC_GND;
         5'h16:   src_of = AICS_SRC_TEMP;
         5'h17:   src_of = AICS_SRC_BGAP;
         5'h1D:   src_of = AICS_SRC_HIGH_REFERENCE;
         5'h1E:   src_of = AICS_SRC_LOW_REFERENCE;
         5'h1F:   src_of = AICS_SRC_NONE;
         default: src_of = (x <= 5'h0F) ? AICS_SRC_EXT : AICS_SRC_RSVD;
      endcase
   endfunction : src_of
   function automatic logic [11:0] lvl_of(input logic [4:0] x);
      case (x)
         5'h16:   lvl_of = TEMP_LVL;
         5'h17:   lvl_of = BGAP_LVL;
         5'h1D:   lvl_of = 12'hFFF;
         default: lvl_of = (x <= 5'h0F) ? 12'h0A5 + 12'(x) * 12'h0F1 : 12'h000;
      endcase
   endfunction : lvl_of
   task automatic end_of_test();
      if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %0h", $time, m, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
      apb(1'b0, a, 32'h0);
      chk(q, x, m);
   endtask : rd
   task automatic wait_done();
      int n;
      n = 0;
      while (conv_busy !== 1'b0 && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
      chk(n < 3000, 1'b1, "conversion hang");
   endtask : wait_done
   task automatic toggles(output int n);
      logic p;
      n = 0;
      p = conversion_clock;
      repeat (64) begin
         @(posedge sys_clk);
         if (conversion_clock !== p) n++;
         p = conversion_clock;
      end
   endtask : toggles
   task automatic trig(input int s, input logic [7:0] dly, output int n);
      apb(1'b1, AICS_OFF_TRIG, {16'h0, dly, 5'h0, 1'b1, 2'(s)});
      trg <= 4'h1 << s;
      repeat (4) @(posedge sys_clk);
      trg <= 4'h0;
      n = 4;
      while (conv_busy !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      if (n < 100) wait_done();
   endtask : trig
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      end_of_test();
   end
   initial begin
      {sys_clk, rst, psel, penable, pwrite, paddr, pwdata} = '0;
      {wait_mode, deep_stop_mode, ckdiv, trg, bad_count, checked} = '0;
      rst = 1'b1;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd(AICS_OFF_CHAN, 32'h1F, "channel reset");
      rd(AICS_OFF_TRIG, 32'h0, "trigger reset");
      chk(input_src, AICS_SRC_NONE, "source reset");
      for (int i = 0; i < 32; i++) begin
         c = (i == 22) ? 5'h17 : (i == 23) ? 5'h16 : 5'(i);
         apb(1'b1, AICS_OFF_CHAN, {27'h0, c});
         repeat (2) @(posedge sys_clk);
         chk(ext_pin_sel, (c <= 5'h0F) ? 16'h0001 << c : 16'h0, "pin select");
         chk(input_src, src_of(c), "input source");
         chk(module_enable, c != 5'h1F, "enable");
         chk(conv_busy, c != 5'h1F, "conversion start");
         wait_done();
         rd(AICS_OFF_STAT, 32'h2, "status");
         if (src_of(c) < AICS_SRC_RSVD) rd(AICS_OFF_RESULT, {20'h0, lvl_of(c)}, "result");
      end
      apb(1'b1, AICS_OFF_CHAN, 32'h0);
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, AICS_OFF_CLK, s);
         toggles(k);
         chk(k > 0, 1'b1, "clock source idle");
         if (s == 0) n0 = k;
      end
      apb(1'b1, AICS_OFF_CLK, 32'hC);
      rd(AICS_OFF_CLK, 32'hC, "divider readback");
      toggles(k);
      chk(k < n0 && k > 0, 1'b1, "divider");
      wait_mode <= 1'b1;
      apb(1'b1, AICS_OFF_CLK, 32'h3);
      toggles(k);
      chk(k > 0, 1'b1, "alt clock in wait");
      deep_stop_mode <= 1'b1;
      repeat (8) @(posedge sys_clk);
      toggles(k);
      chk(k, 32'h0, "alt clock in stop");
      deep_stop_mode <= 1'b0;
      apb(1'b1, AICS_OFF_CLK, 32'h0);
      for (int s = 0; s < 4; s++) begin
         wait_mode <= s[0];
         trig(s, 8'h00, k);
         chk(k < 100, 1'b1, "trigger run and wait");
      end
      trig(2, 8'h20, k);
      chk(k > 32 && k < 100, 1'b1, "trigger delay");
      deep_stop_mode <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         trig(s, 8'h00, k);
         chk(k < 100, s == 1, "trigger in stop");
      end
      deep_stop_mode <= 1'b0;
      rd(8'h40, 32'h0, "unmapped read");
      chk(e, 1'b1, "unmapped error");
      apb(1'b1, 8'h40, 32'h1F);
      rd(AICS_OFF_CHAN, 32'h0, "unmapped write");
      end_of_test();
   end
endmodule : aics_top_tb
